// File: rtl/prd_top.sv
// Parallel speed reference decoder with AXI4-Lite configuration and monitor
//
// Operation
// - Format select 0..7, reset 0, picks decode
// - Five-digit BCD only with wide card fitted; code keeps it in use if the card is removed after it was taken up
// - Display select two or more forces BCD
// - Decode uses format and width switch
// - Display 2..39 means rpm, poles given
// - Display 40..39999 means user units
// - Low four digits scale, fifth gives decimals
// - Binary reads 12 or 16 weighted bits
// - Display select 0..39999, sets monitor units
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`include "prd_regs.svh"
module prd_top (
    // Clock, reset, enable
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              ce,
    // Parallel reference pins
    input  wire logic [11:0]       low_input_connector,
    input  wire logic [3:0]        high_input_connector,
    input  wire logic              sign_in,
    input  wire logic              read_strobe,
    input  wire logic              input_width_switch,
    input  wire logic              wide_card_fitted,
    // Decoded reference
    output logic signed [17:0]     ref_value,
    output prd_pkg::prd_unit_t     ref_unit,
    output logic [1:0]             ref_decimals,
    output logic [15:0]            ref_scale,
    output logic                   ref_update,
    // AXI4-Lite write address
    input  wire logic [3:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [3:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    import prd_pkg::*;

    // Configuration and captured inputs
    prd_format_t  format_reg;
    prd_format_t  eff_format_reg;
    prd_display_t display_reg;
    logic [15:0]  data_reg;
    logic         sign_reg;
    logic         captured_reg;
    logic         bcd_error_reg;
    // Bus state
    logic         awready_reg;
    logic         wready_reg;
    logic         bvalid_reg;
    logic [1:0]   bresp_reg;
    logic [3:0]   awaddr_reg;
    logic [31:0]  wdata_reg;
    logic [3:0]   wstrb_reg;
    logic         arready_reg;
    logic         rvalid_reg;
    logic [31:0]  rdata_reg;
    logic [1:0]   rresp_reg;
    // Output flops
    logic signed [17:0] ref_value_reg;
    prd_unit_t    ref_unit_reg;
    logic [1:0]   ref_decimals_reg;
    logic [15:0]  ref_scale_reg;
    logic         ref_update_reg;

    ////////////////////////////////////////////////////////////////////////
    // Display selector split into decimals digit and four-digit scale
    wire logic        disp_ge2   = (display_reg >= `PRD_DISPLAY_RPM_MIN);
    wire logic        disp_user  = (display_reg >= `PRD_DISPLAY_USER_MIN);
    wire logic [1:0]  disp_fifth = (display_reg >= `PRD_DISPLAY_30000) ? 2'h3 :
                                   (display_reg >= `PRD_DISPLAY_20000) ? 2'h2 :
                                   (display_reg >= `PRD_DISPLAY_10000) ? 2'h1 : 2'h0;
    wire logic [15:0] disp_sub   = (disp_fifth == 2'h3) ? `PRD_DISPLAY_30000 :
                                   (disp_fifth == 2'h2) ? `PRD_DISPLAY_20000 :
                                   (disp_fifth == 2'h1) ? `PRD_DISPLAY_10000 : 16'h0000;
    wire logic [15:0] disp_low   = 16'(display_reg - disp_sub);

    ////////////////////////////////////////////////////////////////////////
    // Mode selection from selectors and width switch
    wire logic        mode_bcd   = disp_ge2 || (eff_format_reg != `PRD_FMT_BINARY);
    wire logic        mode_five  = !disp_ge2 && (eff_format_reg == `PRD_FMT_FIVE_DIGIT);
    // 12-bit word: upper nibble masked so stray pins cannot leak in
    wire logic [15:0] data_used  = input_width_switch ? data_reg
                                                      : {4'h0, data_reg[11:0]};
    // Five-digit form shifts by one: lowest digit is even, sign pin is data
    wire logic [19:0] digits     = mode_five ? {2'b00, sign_reg, data_reg, 1'b0}
                                             : {4'h0, data_used};
    wire logic [2:0]  num_digits = mode_five          ? `PRD_DIGITS_FIVE :
                                   input_width_switch ? `PRD_DIGITS_WIDE
                                                      : `PRD_DIGITS_NARROW;
    wire logic [16:0] bcd_mag;
    wire logic        bcd_bad;

    prd_bcd_to_bin u_bcd (
        .digits_in   (digits),
        .num_digits  (num_digits),
        .value_out   (bcd_mag),
        .digit_error (bcd_bad)
    );

    ////////////////////////////////////////////////////////////////////////
    // Magnitude, sign and value
    wire logic [16:0] bin_mag    = {1'b0, data_used};
    wire logic [16:0] magnitude  = mode_bcd ? bcd_mag : bin_mag;
    wire logic        negative   = sign_reg && !mode_five;
    wire logic [17:0] mag_ext    = {1'b0, magnitude};
    wire logic [17:0] value_next = negative ? 18'(-mag_ext) : mag_ext;

    ////////////////////////////////////////////////////////////////////////
    // Unit, decimals and scale of the decoded value
    prd_unit_t   unit_next;
    logic [1:0]  dec_next;
    logic [15:0] scale_next;

    always_comb begin
        unit_next  = PRD_UNIT_HZ;
        dec_next   = 2'h0;
        scale_next = 16'h0000;
        if (disp_user) begin
            unit_next  = PRD_UNIT_USER;
            dec_next   = disp_fifth;
            scale_next = disp_low;
        end else if (disp_ge2) begin
            unit_next  = PRD_UNIT_RPM;
            scale_next = display_reg;
        end else begin
            case (eff_format_reg)
                3'h0: begin
                    unit_next = PRD_UNIT_PCT;
                end
                3'h1: begin
                    unit_next = PRD_UNIT_PCT;
                    dec_next  = 2'h1;
                end
                3'h2: begin
                    unit_next = PRD_UNIT_PCT;
                    dec_next  = 2'h2;
                end
                3'h3: begin
                    unit_next = PRD_UNIT_HZ;
                end
                3'h4: begin
                    unit_next = PRD_UNIT_HZ;
                    dec_next  = 2'h1;
                end
                3'h5, 3'h6: begin
                    unit_next = PRD_UNIT_HZ;
                    dec_next  = 2'h2;
                end
                3'h7: begin
                    unit_next  = PRD_UNIT_BIN;
                    scale_next = input_width_switch ? `PRD_BIN16_FULL_SCALE
                                                    : {2'h0, `PRD_BIN12_FULL_SCALE};
                end
                default: begin
                    unit_next = PRD_UNIT_HZ;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Capture of the parallel word, only while the strobe is high
    wire logic capture = ce && read_strobe;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            data_reg     <= 16'h0000;
            sign_reg     <= 1'b0;
            captured_reg <= 1'b0;
        end else if (ce) begin
            captured_reg <= read_strobe;
            if (capture) begin
                data_reg <= {high_input_connector, low_input_connector};
                sign_reg <= sign_in;
            end
        end
    end

    // Re-decoded every cycle so a selector change shows at once
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ref_value_reg    <= 18'h00000;
            ref_unit_reg     <= PRD_UNIT_HZ;
            ref_decimals_reg <= 2'h0;
            ref_scale_reg    <= 16'h0000;
            ref_update_reg   <= 1'b0;
            bcd_error_reg    <= 1'b0;
        end else if (ce) begin
            ref_value_reg    <= value_next;
            ref_unit_reg     <= unit_next;
            ref_decimals_reg <= dec_next;
            ref_scale_reg    <= scale_next;
            ref_update_reg   <= captured_reg;
            bcd_error_reg    <= mode_bcd && bcd_bad;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write decode with byte lanes
    wire logic        aw_take    = s_axi_awvalid && awready_reg;
    wire logic        w_take     = s_axi_wvalid && wready_reg;
    wire logic        wr_go      = !awready_reg && !wready_reg && !bvalid_reg;
    wire logic        wr_fmt     = (awaddr_reg == `PRD_FORMAT_OFFSET);
    wire logic        wr_disp    = (awaddr_reg == `PRD_DISPLAY_OFFSET);
    wire logic        wr_mapped  = wr_fmt || wr_disp ||
                                   (awaddr_reg == `PRD_MONITOR_OFFSET) ||
                                   (awaddr_reg == `PRD_STATUS_OFFSET);
    wire prd_display_t disp_merge = {wstrb_reg[1] ? wdata_reg[15:8] : display_reg[15:8],
                                     wstrb_reg[0] ? wdata_reg[7:0]  : display_reg[7:0]};
    // Out-of-range values are dropped, not clipped
    wire logic        disp_ok    = (disp_merge <= `PRD_DISPLAY_MAX);
    wire logic        fmt_load   = wr_go && wr_fmt && wstrb_reg[0];
    wire logic        disp_load  = wr_go && wr_disp && (|wstrb_reg[1:0]) && disp_ok;
    // Five-digit code without the wide card keeps the old form
    wire logic        fmt_allowed = (format_reg != `PRD_FMT_FIVE_DIGIT) ||
                                    wide_card_fitted;

    // Configuration registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            format_reg     <= `PRD_FORMAT_RESET;
            eff_format_reg <= `PRD_FORMAT_RESET;
            display_reg    <= `PRD_DISPLAY_RESET;
        end else if (ce) begin
            if (fmt_load) begin
                format_reg <= wdata_reg[2:0];
            end
            if (fmt_allowed) begin
                eff_format_reg <= format_reg;
            end
            if (disp_load) begin
                display_reg <= disp_merge;
            end
        end
    end

    // Write: address and data in either order, then response
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `PRD_RESP_OKAY;
            awaddr_reg  <= 4'h0;
            wdata_reg   <= 32'h00000000;
            wstrb_reg   <= 4'h0;
        end else if (ce) begin
            if (aw_take) begin
                awaddr_reg  <= {s_axi_awaddr[3:2], 2'h0};
                awready_reg <= 1'b0;
            end
            if (w_take) begin
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
                wready_reg <= 1'b0;
            end
            if (wr_go) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_mapped ? `PRD_RESP_OKAY : `PRD_RESP_DECERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg  <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read decode
    wire logic        ar_take    = s_axi_arvalid && arready_reg;
    wire logic [3:0]  rd_addr    = {s_axi_araddr[3:2], 2'h0};
    wire logic [31:0] status_word =
        (32'(ref_unit_reg)       << `PRD_ST_UNIT_LSB) |
        (32'(ref_decimals_reg)   << `PRD_ST_DEC_LSB) |
        (32'(bcd_error_reg)      << `PRD_ST_BCD_ERR_BIT) |
        (32'(input_width_switch) << `PRD_ST_WIDE_BIT) |
        (32'(wide_card_fitted)   << `PRD_ST_CARD_BIT) |
        (32'(eff_format_reg)     << `PRD_ST_EFF_FMT_LSB) |
        (32'(ref_scale_reg)      << `PRD_ST_SCALE_LSB);
    wire logic        rd_fmt     = (rd_addr == `PRD_FORMAT_OFFSET);
    wire logic        rd_disp    = (rd_addr == `PRD_DISPLAY_OFFSET);
    wire logic        rd_mon     = (rd_addr == `PRD_MONITOR_OFFSET);
    wire logic        rd_stat    = (rd_addr == `PRD_STATUS_OFFSET);
    wire logic [31:0] rd_word    =
        rd_fmt  ? {29'h0, format_reg} :
        rd_disp ? {16'h0000, display_reg} :
        rd_mon  ? {{14{ref_value_reg[17]}}, ref_value_reg} :
        rd_stat ? status_word : 32'h00000000;
    wire logic        rd_mapped  = rd_fmt || rd_disp || rd_mon || rd_stat;

    // Read: one at a time, data a cycle after the address
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h00000000;
            rresp_reg   <= `PRD_RESP_OKAY;
        end else if (ce) begin
            if (ar_take) begin
                arready_reg <= 1'b0;
                rvalid_reg  <= 1'b1;
                rdata_reg   <= rd_word;
                rresp_reg   <= rd_mapped ? `PRD_RESP_OKAY : `PRD_RESP_DECERR;
            end else if (rvalid_reg && s_axi_rready) begin
                rvalid_reg  <= 1'b0;
                arready_reg <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ports straight from flops
    assign ref_value     = ref_value_reg;
    assign ref_unit      = ref_unit_reg;
    assign ref_decimals  = ref_decimals_reg;
    assign ref_scale     = ref_scale_reg;
    assign ref_update    = ref_update_reg;
    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
endmodule

// File: rtl/prd_regs.svh
// Register offsets, field positions, reset values and fixed counts of the reference decoder
`ifndef PRD_REGS_SVH
`define PRD_REGS_SVH

// Byte offsets of the register words
`define PRD_FORMAT_OFFSET       4'h0
`define PRD_DISPLAY_OFFSET      4'h4
`define PRD_MONITOR_OFFSET      4'h8
`define PRD_STATUS_OFFSET       4'hc

// Field positions in the status word
`define PRD_ST_UNIT_LSB         0
`define PRD_ST_DEC_LSB          4
`define PRD_ST_BCD_ERR_BIT      8
`define PRD_ST_WIDE_BIT         9
`define PRD_ST_CARD_BIT         10
`define PRD_ST_EFF_FMT_LSB      12
`define PRD_ST_SCALE_LSB        16

// Reset values
`define PRD_FORMAT_RESET        3'h0
`define PRD_DISPLAY_RESET       16'h0000

// Selector codes and limits
`define PRD_FMT_FIVE_DIGIT      3'h6
`define PRD_FMT_BINARY          3'h7
`define PRD_DISPLAY_MAX         16'h9c3f
`define PRD_DISPLAY_RPM_MIN     16'h0002
`define PRD_DISPLAY_USER_MIN    16'h0028
`define PRD_DISPLAY_10000       16'h2710
`define PRD_DISPLAY_20000       16'h4e20
`define PRD_DISPLAY_30000       16'h7530

// Binary full scale figures
`define PRD_BIN12_FULL_SCALE    14'h0fff
`define PRD_BIN16_FULL_SCALE    16'h7530

// Digit counts of the BCD forms
`define PRD_DIGITS_NARROW       3'h3
`define PRD_DIGITS_WIDE         3'h4
`define PRD_DIGITS_FIVE         3'h5

// Bus responses
`define PRD_RESP_OKAY           2'h0
`define PRD_RESP_DECERR         2'h3

`endif

// File: rtl/prd_pkg.sv
// Types shared by the parallel reference decoder files
package prd_pkg;
    typedef enum logic [2:0] {
        PRD_UNIT_HZ   = 3'h0,
        PRD_UNIT_PCT  = 3'h1,
        PRD_UNIT_BIN  = 3'h2,
        PRD_UNIT_RPM  = 3'h3,
        PRD_UNIT_USER = 3'h4
    } prd_unit_t;

    typedef logic [2:0]  prd_format_t;
    typedef logic [15:0] prd_display_t;
endpackage

// File: rtl/prd_bcd_to_bin.sv
// Weighted sum of up to five BCD digits into a binary magnitude
`timescale 1ns/10ps
module prd_bcd_to_bin (
    // Digits, lowest digit in the low nibble
    input  wire logic [19:0] digits_in,
    input  wire logic [2:0]  num_digits,
    // Result
    output logic      [16:0] value_out,
    output logic             digit_error
);
    logic [16:0] partial [0:5];
    logic [4:0]  bad;

    assign partial[0] = 17'h00000;

    ////////////////////////////////////////////////////////////////////////
    // One stage per digit; digits above the count are ignored
    genvar i;
    generate
        for (i = 0; i < 5; i = i + 1) begin : g_digit
            localparam logic [16:0] WEIGHT = 17'(10 ** i);
            wire logic [3:0]  digit = digits_in[4*i +: 4];
            wire logic        used  = (3'(i) < num_digits);
            wire logic [16:0] term  = 17'(digit * WEIGHT);
            assign partial[i+1] = used ? 17'(partial[i] + term) : partial[i];
            // A nibble above nine is still summed, but flagged
            assign bad[i] = used && (digit > 4'h9);
        end
    endgenerate

    assign value_out   = partial[5];
    assign digit_error = |bad;
endmodule

// File: verification/prd_ref_source.sv
// Model of the external controller that drives the parallel reference pins
`timescale 1ns/10ps
module prd_ref_source (
    // Clock
    input  wire logic        clk,
    // Parallel reference pins
    output logic      [11:0] low_input_connector,
    output logic      [3:0]  high_input_connector,
    output logic             sign_in,
    output logic             read_strobe
);
    ////////////////////////////////////////
    // Idle lines at time zero, strobe low
    initial {low_input_connector, high_input_connector, sign_in, read_strobe} = '0;

    // Word and sign stand for every strobe edge; hold sets the edges
    task automatic send(input logic [15:0] word, input logic sgn, input int hold);
        low_input_connector  <= word[11:0];
        high_input_connector <= word[15:12];
        sign_in              <= sgn;
        read_strobe          <= 1'b1;
        repeat (hold) @(posedge clk);
        // Released lines show the inverse, so a late capture cannot hide
        low_input_connector  <= ~word[11:0];
        high_input_connector <= ~word[15:12];
        sign_in              <= ~sgn;
        read_strobe          <= 1'b0;
    endtask
endmodule

// File: verification/prd_top_properties.sv
// Concurrent checks on the decoder ports
`timescale 1ns/10ps
`include "prd_regs.svh"
module prd_top_checker (
    // Clock, reset, enable
    input wire logic               clk,
    input wire logic               reset,
    input wire logic               ce,
    // Parallel pins
    input wire logic [11:0]        low_input_connector,
    input wire logic [3:0]         high_input_connector,
    input wire logic               sign_in,
    input wire logic               read_strobe,
    input wire logic               input_width_switch,
    // Decoded reference
    input wire logic signed [17:0] ref_value,
    input wire prd_pkg::prd_unit_t ref_unit,
    input wire logic [1:0]         ref_decimals,
    input wire logic [15:0]        ref_scale,
    input wire logic               ref_update,
    // Bus handshakes
    input wire logic [1:0]         s_axi_bresp,
    input wire logic               s_axi_bvalid,
    input wire logic               s_axi_bready,
    input wire logic               s_axi_arvalid,
    input wire logic               s_axi_arready,
    input wire logic               s_axi_rvalid
);
    import prd_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Binary decode: masked word, sign folded in
    function automatic logic signed [17:0] bin_val(logic [15:0] w, logic s, logic wide);
        logic signed [17:0] m;
        m = {2'b00, (wide ? w : {4'h0, w[11:0]})};
        return s ? -m : m;
    endfunction

    ////////////////////////////////////////
    // Capture and decode
    a_update_follows_strobe: assert property (
        ce && read_strobe |-> ##2 ref_update) else $error("update missing after strobe");
    a_update_needs_strobe: assert property (
        ref_update |-> $past(read_strobe, 2)) else $error("update without strobe");
    a_binary_value: assert property (
        ref_update && ref_unit == PRD_UNIT_BIN |-> ref_value == bin_val(
            $past({high_input_connector, low_input_connector}, 2), $past(sign_in, 2),
            $past(input_width_switch))) else $error("binary value wrong");
    a_binary_scale: assert property (
        ref_unit == PRD_UNIT_BIN |-> ref_scale == ($past(input_width_switch) ? 16'h7530
        : 16'h0fff)) else $error("binary full scale wrong");
    a_rpm_scale: assert property (
        ref_unit == PRD_UNIT_RPM |-> ref_scale inside {[16'h0002:16'h0027]}
        && ref_decimals == 2'h0) else $error("rpm pole count wrong");
    a_user_scale: assert property (
        ref_unit == PRD_UNIT_USER |-> ref_scale <= 16'h270f) else $error("user scale wrong");
    a_sign_applied: assert property (
        ref_update && ref_unit != PRD_UNIT_HZ |-> ($past(sign_in, 2) ? ref_value <= 0
        : ref_value >= 0)) else $error("sign not applied");
    // Bus answers; every offset is mapped, so writes always succeed
    a_write_okay: assert property (
        s_axi_bvalid |-> s_axi_bresp == `PRD_RESP_OKAY) else $error("write refused");
    a_read_answers: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered");
    a_bresp_holds: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write response dropped");
    // Main scenarios
    c_binary: cover property (ref_update && ref_unit == PRD_UNIT_BIN);
    c_rpm: cover property (ref_update && ref_unit == PRD_UNIT_RPM);
    c_user: cover property (ref_update && ref_unit == PRD_UNIT_USER && ref_decimals == 2'h3);
endmodule

bind prd_top prd_top_checker chk_u (.*);

// File: verification/prd_top_tb.sv
// Self-checking bench for the parallel reference decoder
`timescale 1ns/10ps
`include "prd_regs.svh"
module prd_top_tb;
    import prd_pkg::*;
    logic               clk, reset, ce, input_width_switch, wide_card_fitted;
    logic        [11:0] low_input_connector;
    logic        [3:0]  high_input_connector, s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    logic               sign_in, read_strobe, ref_update;
    logic signed [17:0] ref_value;
    prd_unit_t          ref_unit;
    logic        [1:0]  ref_decimals, s_axi_bresp, s_axi_rresp;
    logic        [15:0] ref_scale;
    logic        [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic               s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic               s_axi_rvalid, s_axi_rready;
    int                 error_cnt, n_compared;
    // Selector boundaries: display, unit, decimals, scale
    localparam logic [39:0] tab [5] = '{40'h0027_3_0_0027, 40'h0028_4_0_0028,
        40'h2710_4_1_0000, 40'h52f2_4_2_04d2, 40'h9c3f_4_3_270f};

    ////////////////////////////////////////
    // Design and far-side controller
    prd_top dut_u (.*);
    prd_ref_source src_u (.*);

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    ////////////////////////////////////////
    // Compare, count, report
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Write: address and data together, each dropped once taken
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(s_axi_bresp), 0);
        @(posedge clk);
    endtask

    task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        chk("rresp", 32'(s_axi_rresp), 0);
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask

    // One strobe; the decode stands from the edge after capture
    task automatic run(input logic [15:0] w, input logic s, input int v, input prd_unit_t u,
                       input logic [1:0] d, input logic [15:0] sc);
        src_u.send(w, s, 1);
        repeat (2) @(posedge clk);
        chk("update", 32'(ref_update), 1);
        chk("value", 32'(ref_value), v);
        chk("unit", 32'(ref_unit), 32'(u));
        chk("decimals", 32'(ref_decimals), 32'(d));
        chk("scale", 32'(ref_scale), 32'(sc));
    endtask

    ////////////////////////////////////////
    // Hang guard, far beyond the sequence
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        summarize();
    end

    initial begin
        reset = 1'b1;
        ce = 1'b1;
        input_width_switch = 1'b0;
        wide_card_fitted = 1'b1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        axi_read(`PRD_FORMAT_OFFSET, rd);
        chk("format", rd, 32'h0);
        axi_read(`PRD_DISPLAY_OFFSET, rd);
        chk("display", rd, 32'h0);
        // Signed BCD codes on a narrow word, then on a wide one; the narrow top nibble must be masked
        for (int f = 0; f < 6; f++) begin
            axi_write(`PRD_FORMAT_OFFSET, 32'(f), 4'hf);
            run(16'h9123, 1'b1, -123, (f < 3) ? PRD_UNIT_PCT : PRD_UNIT_HZ, 2'(f % 3), 16'h0);
        end
        input_width_switch <= 1'b1;
        run(16'h4321, 1'b0, 4321, PRD_UNIT_HZ, 2'h2, 16'h0);
        // Binary at both widths
        axi_write(`PRD_FORMAT_OFFSET, 32'h7, 4'hf);
        run(16'h7530, 1'b1, -30000, PRD_UNIT_BIN, 2'h0, 16'h7530);
        axi_read(`PRD_MONITOR_OFFSET, rd);
        chk("monitor", rd, -32'sd30000);
        input_width_switch <= 1'b0;
        run(16'hffff, 1'b0, 4095, PRD_UNIT_BIN, 2'h0, 16'h0fff);
        // Slow controller; lines released afterwards must not be taken
        src_u.send(16'h0abc, 1'b1, 3);
        repeat (4) @(posedge clk);
        chk("held", 32'(ref_value), -32'sd2748);
        chk("update", 32'(ref_update), 0);
        // Enable low: a strobe must change nothing
        ce <= 1'b0;
        src_u.send(16'h0123, 1'b0, 2);
        repeat (2) @(posedge clk);
        ce <= 1'b1;
        chk("frozen", 32'(ref_value), -32'sd2748);
        // Five-digit code has no effect without the wide card
        wide_card_fitted <= 1'b0;
        input_width_switch <= 1'b1;
        axi_write(`PRD_FORMAT_OFFSET, 32'h6, 4'hf);
        axi_read(`PRD_FORMAT_OFFSET, rd);
        chk("format", rd, 32'h6);
        run(16'h0005, 1'b0, 5, PRD_UNIT_BIN, 2'h0, 16'h7530);
        wide_card_fitted <= 1'b1;
        axi_write(`PRD_FORMAT_OFFSET, 32'h6, 4'hf);
        run(16'hcccc, 1'b1, 39998, PRD_UNIT_HZ, 2'h2, 16'h0);
        // Format lane disabled: write leaves the selector alone
        axi_write(`PRD_FORMAT_OFFSET, 32'h0, 4'he);
        axi_read(`PRD_FORMAT_OFFSET, rd);
        chk("format", rd, 32'h6);
        // Display two or more forces signed BCD over the binary code
        axi_write(`PRD_FORMAT_OFFSET, 32'h7, 4'hf);
        axi_write(`PRD_DISPLAY_OFFSET, 32'h4, 4'hf);
        run(16'h1500, 1'b1, -1500, PRD_UNIT_RPM, 2'h0, 16'h0004);
        foreach (tab[i]) begin
            axi_write(`PRD_DISPLAY_OFFSET, {16'h0, tab[i][39:24]}, 4'hf);
            run(16'h0999, 1'b0, 999, prd_unit_t'(tab[i][22:20]), tab[i][17:16],
                tab[i][15:0]);
        end
        // Display above its range is dropped
        axi_write(`PRD_DISPLAY_OFFSET, 32'h0000_9c40, 4'hf);
        axi_read(`PRD_DISPLAY_OFFSET, rd);
        chk("display", rd, 32'h0000_9c3f);
        summarize();
    end
endmodule
